//--- tb/seap_access_port_assertions.sv
`timescale 1ns/10ps
module seap_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        upstream_port_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_rvalid_o,
  input wire logic        autoload_done_i,
  input wire logic        autoload_ok_i,
  input wire logic        autoload_disable_o,
  input wire logic        autoload_commit_o,
  input wire logic        eeprom_scl_o
);
  wire rd_ok   = cfg_rd_i && upstream_port_i && cfg_addr_i == 8'hbc;
  wire load_ok = autoload_done_i && autoload_ok_i && !autoload_disable_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_read_answered: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  a_hidden_zero: assert property (cfg_rd_i && !rd_ok |=> cfg_rdata_o == 32'h0)
    else $error("hidden read not zero");
  a_commit_load: assert property (load_ok |=> autoload_commit_o)
    else $error("commit missing");
  a_no_commit: assert property (autoload_done_i && autoload_disable_o |=> !autoload_commit_o)
    else $error("commit while disabled");
  a_status_load: assert property (load_ok ##1 (!autoload_done_i && !cfg_rd_i) ##1 rd_ok |=> cfg_rdata_o[4:3] == 2'h3)
    else $error("load status missing");
  a_read_clears: assert property ((rd_ok && !load_ok) ##1 !load_ok ##1 rd_ok |=> !cfg_rdata_o[3])
    else $error("success flag not cleared");
  a_disable_seen: assert property (rd_ok |=> cfg_rdata_o[5] == $past(autoload_disable_o))
    else $error("disable bit mismatch");
  a_reset_state: assert property ($rose(rst_b_i) |-> autoload_disable_o && eeprom_scl_o)
    else $error("bad state after reset");
  a_scl_high_hold: assert property ($rose(eeprom_scl_o) |-> eeprom_scl_o[*4])
    else $error("serial clock high too short");
  c_load: cover property (load_ok ##1 autoload_commit_o);
  c_error_seen: cover property (rd_ok ##1 cfg_rdata_o[2]);
  c_busy_seen: cover property (rd_ok ##1 cfg_rdata_o[0]);
endmodule : seap_chk
bind seap_access_port seap_chk seap_chk_inst (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .upstream_port_i(upstream_port_i),
  .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_rvalid_o(cfg_rvalid_o), .autoload_done_i(autoload_done_i),
  .autoload_ok_i(autoload_ok_i), .autoload_disable_o(autoload_disable_o),
  .autoload_commit_o(autoload_commit_o), .eeprom_scl_o(eeprom_scl_o));

//--- tb/seap_access_port_tb_top.sv
`timescale 1ns/10ps
module seap_access_port_tb_top;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic        up         = 1'b1;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic        done       = 1'b0;
  logic        ok         = 1'b0;
  logic        nack       = 1'b0;
  logic [7:0]  addr       = 8'hbc;
  logic [31:0] wdata      = 32'h0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic        rvalid, dis, commit, scl, sda_o, sda_oe, pull;
  logic [6:0]  atab [3]   = '{7'h00, 7'h7f, 7'h2a};
  logic [15:0] wtab [3]   = '{16'ha55a, 16'h0001, 16'h8000};
  int          errors     = 0;
  int          checks     = 0;
  int          n;
  wire         sda = !((sda_oe && !sda_o) || pull);
  initial forever #50 core_clk_i = !core_clk_i;
  seap_access_port seap_access_port_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .upstream_port_i(up), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(4'hf),
    .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .autoload_done_i(done),
    .autoload_ok_i(ok), .autoload_disable_o(dis), .autoload_commit_o(commit),
    .eeprom_scl_o(scl), .eeprom_sda_i(sda), .eeprom_sda_o(sda_o), .eeprom_sda_oe_o(sda_oe));
  seap_eeprom_model seap_eeprom_model_inst (.clk_i(core_clk_i), .scl_i(scl), .sda_i(sda),
    .nack_i(nack), .pull_low_o(pull));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
    check("read answer", 32'(rvalid), 32'h1);
  endtask : reg_rd
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic wait_idle(output logic [31:0] d);
    for (int i = 0; i < 30000; i++) begin
      reg_rd(8'hbc, d);
      if (d[0] === 1'b0) return;
    end
    errors++;
    tally_and_finish;
  endtask : wait_idle
  // The second write lands while the cycle is busy and must be dropped whole.
  task automatic cycle(input logic [31:0] c, output logic [31:0] d);
    reg_wr(8'hbc, c);
    reg_wr(8'hbc, 32'h0);
    wait_idle(d);
  endtask : cycle
  task automatic hold(input logic lvl, inout int cnt);
    for (int i = 0; i < 2000; i++) begin
      @(posedge core_clk_i);
      cnt++;
      #1 if (scl !== lvl) return;
    end
    errors++;
    tally_and_finish;
  endtask : hold
  task automatic pulse(input logic o, input logic exp);
    @(posedge core_clk_i);
    done <= 1'b1;
    ok <= o;
    @(posedge core_clk_i);
    done <= 1'b0;
    #1 check("commit", 32'(commit), 32'(exp));
  endtask : pulse
  function automatic logic [31:0] mk(input logic [15:0] d, input logic [6:0] a,
                                     input logic w, input logic [1:0] r);
    return {d, a, 1'b0, r, 1'b1, 3'h0, w, 1'b1};
  endfunction : mk
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    reg_rd(8'hbc, v);
    check("reset value", v, 32'h0000_0060);
    reg_wr(8'hbc, 32'hffff_ffde);
    reg_rd(8'hbc, v);
    check("field access", v, 32'hffff_fec2);
    reg_wr(8'hb8, 32'h0);
    @(posedge core_clk_i);
    up <= 1'b0;
    reg_wr(8'hbc, 32'h0);
    reg_rd(8'hbc, v);
    check("hidden read", v, 32'h0);
    @(posedge core_clk_i);
    up <= 1'b1;
    reg_rd(8'hb8, v);
    check("other offset", v, 32'h0);
    reg_rd(8'hbc, v);
    check("writes ignored", v, 32'hffff_fec2);
    $display("test registers done");
    foreach (atab[i]) begin
      cycle(mk(wtab[i], atab[i], 1'b1, 2'h3), v);
      check("write status", 32'(v[2:0]), 32'h2);
    end
    foreach (atab[i]) begin
      cycle(mk(16'h0, atab[i], 1'b0, 2'h3), v);
      check("read data", 32'(v[31:16]), 32'(wtab[i]));
      check("read status", 32'(v[2:0]), 32'h0);
    end
    $display("test transfers done");
    @(posedge core_clk_i);
    nack <= 1'b1;
    cycle(mk(16'h1234, 7'h00, 1'b0, 2'h3), v);
    check("refused read", v, 32'h1234_00e4);
    @(posedge core_clk_i);
    nack <= 1'b0;
    cycle(mk(16'h0, 7'h00, 1'b0, 2'h3), v);
    check("error cleared", v, 32'ha55a_00e0);
    $display("test acknowledge done");
    reg_wr(8'hbc, 32'h0000_0040);
    pulse(1'b0, 1'b0);
    reg_rd(8'hbc, v);
    check("failed load", 32'(v[5:3]), 32'h0);
    pulse(1'b1, 1'b1);
    reg_rd(8'hbc, v);
    check("load status", 32'(v[5:3]), 32'h3);
    reg_rd(8'hbc, v);
    check("after read", 32'(v[5:3]), 32'h2);
    reg_wr(8'hbc, 32'h0000_0060);
    pulse(1'b1, 1'b0);
    $display("test autoload done");
    for (int r = 0; r < 2; r++) begin
      reg_wr(8'hbc, mk(16'hc3c3, 7'h11, 1'b1, r ? 2'h1 : 2'h3));
      hold(1'b1, n);
      hold(1'b0, n);
      n = 0;
      hold(1'b1, n);
      hold(1'b0, n);
      check("clock period", 32'(n), r ? 32'h0000_0400 : 32'h0000_0010);
      wait_idle(v);
    end
    $display("test clock rate done");
    tally_and_finish;
  end
endmodule : seap_access_port_tb_top

//--- tb/seap_eeprom_model.sv
`timescale 1ns/10ps
module seap_eeprom_model (
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic nack_i,
  output logic      pull_low_o
);
  logic [7:0] mem [0:255];
  logic [7:0] sh         = 8'h00;
  logic [7:0] ptr        = 8'h00;
  logic [3:0] bc         = 4'h0;
  logic [2:0] bi         = 3'h0;
  logic       rd         = 1'b0;
  logic       ackd       = 1'b0;
  logic       ps         = 1'b1;
  logic       pd         = 1'b1;
  logic       sel_ok;
  initial pull_low_o = 1'b0;
  assign sel_ok = (sh[7:1] == seap_pkg::DEV_SELECT) && !nack_i;
  // Edges are seen one core clock late, with the clock line already at its new level.
  always @(posedge clk_i) begin
    ps <= scl_i;
    pd <= sda_i;
    if (ps && scl_i && (pd != sda_i)) begin
      // The clock fall that closes a start condition is not a bit, so count from one below zero.
      bc <= 4'hf;
      bi <= 3'h0;
      rd <= 1'b0;
      pull_low_o <= 1'b0;
    end else if (!ps && scl_i) begin
      if (rd && bc == 4'h8) ackd <= !sda_i;
      else sh <= {sh[6:0], sda_i};
    end else if (ps && !scl_i) begin
      bc <= (bc == 4'h8) ? 4'h0 : bc + 4'h1;
      pull_low_o <= 1'b0;
      if (bc == 4'h7 && !rd) begin
        bi <= bi + 3'h1;
        if (bi == 3'h0) begin
          pull_low_o <= sel_ok;
          rd <= sh[0] && sel_ok;
          ackd <= sel_ok;
        end else begin
          pull_low_o <= 1'b1;
          if (bi == 3'h1) ptr <= sh;
          else begin
            mem[ptr] <= sh;
            ptr <= ptr + 8'h01;
          end
        end
      end else if (bc == 4'h7) ptr <= ptr + 8'h01;
      else if (rd && ackd && bc == 4'h8) pull_low_o <= !mem[ptr][7];
      else if (rd && ackd && bc < 4'h7) pull_low_o <= !mem[ptr][3'(4'h6 - bc)];
    end
  end
endmodule : seap_eeprom_model

//--- verilog/seap_access_port.sv
`timescale 1ns/10ps
module seap_access_port (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        upstream_port_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_rvalid_o,
  input  wire logic        autoload_done_i,
  input  wire logic        autoload_ok_i,
  output logic             autoload_disable_o,
  output logic             autoload_commit_o,
  output logic             eeprom_scl_o,
  input  wire logic        eeprom_sda_i,
  output logic             eeprom_sda_o,
  output logic             eeprom_sda_oe_o
);

  logic                     start;
  logic                     cmd;
  logic                     err;
  logic                     al_ok;
  logic                     al_stat;
  logic                     al_dis;
  logic [1:0]               rate;
  logic [6:0]               word_addr;
  logic [15:0]              word_data;
  seap_pkg::seap_state_e    state;
  logic [2:0]               seg;
  logic [1:0]               qtr;
  logic [3:0]               bitn;
  logic [7:0]               tx;
  logic [15:0]              rx;
  logic [seap_pkg::DIV_W-1:0] div;
  logic                     fail;
  logic                     hit;
  logic                     wr_hit;
  logic                     rd_hit;
  logic                     tick;
  logic                     finish;
  logic                     ack_fail;
  logic [2:0]               kind;
  logic [seap_pkg::DIV_W-1:0] qtr_len;
  logic [31:0]              reg_view;

  function automatic logic [2:0] seg_kind(input logic c, input logic [2:0] s);
    logic [2:0] k;
    k = seap_pkg::SK_STOP;
    if (c == seap_pkg::CMD_WRITE) begin
      unique case (s)
        3'h0:                      k = seap_pkg::SK_START;
        3'h1, 3'h2, 3'h3, 3'h4:    k = seap_pkg::SK_WBYTE;
        default:                   k = seap_pkg::SK_STOP;
      endcase
    end else begin
      unique case (s)
        3'h0, 3'h3:                k = seap_pkg::SK_START;
        3'h1, 3'h2, 3'h4:          k = seap_pkg::SK_WBYTE;
        3'h5:                      k = seap_pkg::SK_RACK;
        3'h6:                      k = seap_pkg::SK_RNACK;
        default:                   k = seap_pkg::SK_STOP;
      endcase
    end
    return k;
  endfunction : seg_kind

  // Byte sent in a write segment: select, word address, then data high and low for a write, or the read select for a read.
  function automatic logic [7:0] seg_byte(input logic c, input logic [2:0] s,
                                          input logic [6:0] a, input logic [15:0] d);
    logic [7:0] b;
    b = 8'h00;
    unique case (s)
      3'h1:    b = {seap_pkg::DEV_SELECT, 1'b0};
      3'h2:    b = {a, 1'b0};
      3'h3:    b = d[15:8];
      3'h4:    b = (c == seap_pkg::CMD_WRITE) ? d[7:0] : {seap_pkg::DEV_SELECT, 1'b1};
      default: b = 8'h00;
    endcase
    return b;
  endfunction : seg_byte

  assign hit    = upstream_port_i && (cfg_addr_i == seap_pkg::CFG_OFFSET);
  assign wr_hit = cfg_wr_i && hit && !start;
  assign rd_hit = cfg_rd_i && hit;
  assign kind   = seg_kind(cmd, seg);

  // Reserved codes run at the normal rate; only the test code speeds up.
  assign qtr_len = (rate == seap_pkg::RATE_TEST) ? seap_pkg::QTR_TEST
                                                 : seap_pkg::QTR_NORMAL;
  assign tick    = (state != seap_pkg::SEAP_IDLE) && (div == qtr_len - 1'b1);
  assign finish  = tick && (qtr == 2'h3) && (kind == seap_pkg::SK_STOP);
  assign ack_fail = tick && (state == seap_pkg::SEAP_BYTE) && (qtr == 2'h2) &&
                    (bitn == seap_pkg::ACK_BITN) && (kind == seap_pkg::SK_WBYTE) &&
                    eeprom_sda_i;

  assign reg_view = {word_data, word_addr, 1'b0, rate, al_dis, al_stat, al_ok,
                     err, cmd, start};
  assign autoload_disable_o = al_dis;
  assign eeprom_sda_o       = 1'b0;

  // Control byte. Writes are ignored while a cycle is in flight.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      start  <= seap_pkg::START_RST;
      cmd    <= seap_pkg::CMD_RST;
      al_dis <= seap_pkg::AL_DIS_RST;
      rate   <= seap_pkg::RATE_RST;
    end else if (wr_hit && cfg_be_i[0]) begin
      start  <= cfg_wdata_i[seap_pkg::START_BIT];
      cmd    <= cfg_wdata_i[seap_pkg::CMD_BIT];
      al_dis <= cfg_wdata_i[seap_pkg::AL_DIS_BIT];
      rate   <= cfg_wdata_i[seap_pkg::RATE_LSB +: 2];
    end else if (finish) begin
      start  <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      err <= 1'b0;
    end else if (ack_fail) begin
      err <= 1'b1;
    end else if (state == seap_pkg::SEAP_IDLE && start) begin
      err <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      word_addr <= seap_pkg::ADDR_RST;
    end else if (wr_hit && cfg_be_i[1]) begin
      word_addr <= cfg_wdata_i[seap_pkg::ADDR_LSB +: 7];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      word_data <= seap_pkg::DATA_RST;
    end else if (finish && cmd == seap_pkg::CMD_READ && !fail) begin
      word_data <= rx;
    end else if (wr_hit) begin
      if (cfg_be_i[2]) begin
        word_data[7:0] <= cfg_wdata_i[seap_pkg::DATA_LSB +: 8];
      end
      if (cfg_be_i[3]) begin
        word_data[15:8] <= cfg_wdata_i[seap_pkg::DATA_LSB + 8 +: 8];
      end
    end
  end

  // Autoload flags. A success report in the same cycle as a read wins.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      al_ok             <= 1'b0;
      al_stat           <= 1'b0;
      autoload_commit_o <= 1'b0;
    end else begin
      autoload_commit_o <= autoload_done_i && autoload_ok_i && !al_dis;
      if (autoload_done_i) begin
        al_stat <= autoload_ok_i && !al_dis;
      end
      if (autoload_done_i && autoload_ok_i && !al_dis) begin
        al_ok <= 1'b1;
      end else if (rd_hit) begin
        al_ok <= 1'b0;
      end
    end
  end

  // The answer carries the value as it stood before any read side effect.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cfg_rdata_o  <= 32'h0000_0000;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      cfg_rdata_o  <= rd_hit ? reg_view : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || state == seap_pkg::SEAP_IDLE || tick) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // Segment sequencer. After a missing acknowledge it skips to the stop.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state <= seap_pkg::SEAP_IDLE;
      seg   <= 3'h0;
      qtr   <= 2'h0;
      bitn  <= 4'h0;
      tx    <= 8'h00;
      rx    <= 16'h0000;
      fail  <= 1'b0;
    end else begin
      unique case (state)
        seap_pkg::SEAP_IDLE: begin
          if (start) begin
            state <= seap_pkg::SEAP_COND;
            seg   <= 3'h0;
            qtr   <= 2'h0;
            fail  <= 1'b0;
          end
        end
        seap_pkg::SEAP_COND, seap_pkg::SEAP_BYTE: begin
          if (tick) begin
            qtr <= qtr + 2'h1;
            if (ack_fail) begin
              fail <= 1'b1;
            end
            if (state == seap_pkg::SEAP_BYTE && qtr == 2'h2 &&
                bitn != seap_pkg::ACK_BITN &&
                (kind == seap_pkg::SK_RACK || kind == seap_pkg::SK_RNACK)) begin
              rx <= {rx[14:0], eeprom_sda_i};
            end
            if (qtr == 2'h3) begin
              if (state == seap_pkg::SEAP_BYTE && bitn != seap_pkg::ACK_BITN) begin
                bitn <= bitn + 4'h1;
                tx   <= {tx[6:0], 1'b0};
              end else if (kind == seap_pkg::SK_STOP) begin
                state <= seap_pkg::SEAP_IDLE;
              end else begin
                seg  <= fail ? ((cmd == seap_pkg::CMD_WRITE) ? seap_pkg::SEG_STOP_WR
                                                             : seap_pkg::SEG_STOP_RD)
                             : seg + 3'h1;
                bitn <= 4'h0;
                tx   <= seg_byte(cmd, seg + 3'h1, word_addr, word_data);
                if (!fail && (seg_kind(cmd, seg + 3'h1) == seap_pkg::SK_WBYTE ||
                              seg_kind(cmd, seg + 3'h1) == seap_pkg::SK_RACK ||
                              seg_kind(cmd, seg + 3'h1) == seap_pkg::SK_RNACK)) begin
                  state <= seap_pkg::SEAP_BYTE;
                end else begin
                  state <= seap_pkg::SEAP_COND;
                end
              end
            end
          end
        end
      endcase
    end
  end

  // Pin drive. The data line is open drain: enable high pulls it low.
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      eeprom_scl_o    <= 1'b1;
      eeprom_sda_oe_o <= 1'b0;
    end else if (tick) begin
      unique case (qtr)
        2'h0: begin
          eeprom_scl_o <= 1'b0;
          if (kind == seap_pkg::SK_START) begin
            eeprom_sda_oe_o <= 1'b0;
          end else if (kind == seap_pkg::SK_STOP) begin
            eeprom_sda_oe_o <= 1'b1;
          end else if (bitn == seap_pkg::ACK_BITN) begin
            eeprom_sda_oe_o <= (kind == seap_pkg::SK_RACK);
          end else begin
            eeprom_sda_oe_o <= (kind == seap_pkg::SK_WBYTE) && !tx[7];
          end
        end
        2'h1: begin
          eeprom_scl_o <= 1'b1;
        end
        2'h2: begin
          if (kind == seap_pkg::SK_START) begin
            eeprom_sda_oe_o <= 1'b1;
          end else if (kind == seap_pkg::SK_STOP) begin
            eeprom_sda_oe_o <= 1'b0;
          end
        end
        2'h3: begin
          if (kind != seap_pkg::SK_STOP) begin
            eeprom_scl_o <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule : seap_access_port

//--- verilog/seap_pkg.sv
package seap_pkg;

  // Configuration space location and field positions of the access register.
  localparam logic [7:0] CFG_OFFSET = 8'hbc;
  localparam int START_BIT  = 0;
  localparam int CMD_BIT    = 1;
  localparam int ERR_BIT    = 2;
  localparam int AL_OK_BIT  = 3;
  localparam int AL_ST_BIT  = 4;
  localparam int AL_DIS_BIT = 5;
  localparam int RATE_LSB   = 6;
  localparam int ADDR_LSB   = 9;
  localparam int DATA_LSB   = 16;

  // Values after reset.
  localparam logic        START_RST  = 1'h0;
  localparam logic        CMD_RST    = 1'h0;
  localparam logic        AL_DIS_RST = 1'h1;
  localparam logic [1:0]  RATE_RST   = 2'h1;
  localparam logic [6:0]  ADDR_RST   = 7'h00;
  localparam logic [15:0] DATA_RST   = 16'h0000;

  // Command and clock-rate codes.
  localparam logic       CMD_READ  = 1'h0;
  localparam logic       CMD_WRITE = 1'h1;
  localparam logic [1:0] RATE_TEST = 2'h3;

  // Serial clock divide ratios; each serial bit takes four quarter steps.
  localparam int CLK_DIV_NORMAL = 1024;
  localparam int CLK_DIV_TEST   = 16;
  localparam int DIV_W          = 10;
  localparam logic [DIV_W-1:0] QTR_NORMAL = DIV_W'(CLK_DIV_NORMAL / 4);
  localparam logic [DIV_W-1:0] QTR_TEST   = DIV_W'(CLK_DIV_TEST / 4);

  // Memory device select code on the two-wire bus.
  localparam logic [6:0] DEV_SELECT = 7'h50;

  // Kinds of bus segment.
  localparam logic [2:0] SK_START = 3'h0;
  localparam logic [2:0] SK_WBYTE = 3'h1;
  localparam logic [2:0] SK_RACK  = 3'h2;
  localparam logic [2:0] SK_RNACK = 3'h3;
  localparam logic [2:0] SK_STOP  = 3'h4;

  // Segment index of the stop condition for each command, and the bit number of the acknowledge.
  localparam logic [2:0] SEG_STOP_WR = 3'h5;
  localparam logic [2:0] SEG_STOP_RD = 3'h7;
  localparam logic [3:0] ACK_BITN    = 4'h8;

  typedef enum logic [2:0] {
    SEAP_IDLE = 3'b001,
    SEAP_COND = 3'b010,
    SEAP_BYTE = 3'b100
  } seap_state_e;

endpackage : seap_pkg
